// ===== logic/pesc_params.svh
// Constants for the per-port extended status and counter registers.
// Assumes inclusion by bare name from the logic folder.
`ifndef PESC_PARAMS_SVH
`define PESC_PARAMS_SVH

// ==========================================
// Register addresses.
`define PESC_ADDR_RXERR 5'h13
`define PESC_ADDR_FCAR 5'h14
`define PESC_ADDR_LDROP 5'h15
`define PESC_ADDR_ECS 5'h16
`define PESC_ADDR_EPC1 5'h17
`define PESC_ADDR_EPC2 5'h18

// ==========================================
// Field positions in the extended control/status register.
`define PESC_ECS_FORCE 15
`define PESC_ECS_JAB 14
`define PESC_ECS_ECHO 13
`define PESC_ECS_HBT 12
`define PESC_ECS_SQ_HI 11
`define PESC_ECS_SQ_LO 10
`define PESC_ECS_STKEN 9
`define PESC_ECS_EOF 8
`define PESC_ECS_DISC 7
`define PESC_ECS_LINK 6
`define PESC_ECS_BCAST 0

// Field positions in the two extended control registers.
`define PESC_EPC1_MODE_HI 10
`define PESC_EPC1_MODE_LO 8
`define PESC_EPC1_RSVW_HI 15
`define PESC_EPC1_RSVW_LO 11
`define PESC_EPC1_FELB 3
`define PESC_EPC2_EDGE_HI 15
`define PESC_EPC2_EDGE_LO 13
`define PESC_EPC2_RPWR 12
`define PESC_EPC2_JUMBO_HI 5
`define PESC_EPC2_JUMBO_LO 4
`define PESC_EPC2_CLB 0

// ==========================================
// Reset values.
`define PESC_RST_FORCE 1'h0
`define PESC_RST_JAB 1'h0
`define PESC_RST_ECHO 1'h1
`define PESC_RST_HBT 1'h1
`define PESC_RST_SQ 2'h0
`define PESC_RST_STKEN 1'h1
`define PESC_RST_BCAST 1'h0
`define PESC_RST_MODE 3'h0
`define PESC_RST_RSVW 5'h00
`define PESC_RST_EDGE 3'h1
`define PESC_RST_JUMBO 2'h0
`define PESC_RST_BIT 1'h0

// Counter limits.
`define PESC_CNT_MAX 8'hff
`define PESC_CNT_ONE 8'h01
`define PESC_CNT_ZERO 8'h00

`endif

// ===== logic/pesc_pkg.sv
// Types shared by the extended status counter block.
// Assumes nothing of its surroundings.
`default_nettype none
package pesc_pkg;
    // Squelch threshold selection.
    typedef enum logic [1:0] {
        PESC_SQ_NORMAL = 2'h0,
        PESC_SQ_LOW = 2'h1,
        PESC_SQ_HIGH = 2'h2,
        PESC_SQ_RSVD = 2'h3
    } pesc_sq_t;
    // Maximum packet length selection.
    typedef enum logic [1:0] {
        PESC_JUMBO_STD = 2'h0,
        PESC_JUMBO_9K = 2'h1,
        PESC_JUMBO_12K = 2'h2,
        PESC_JUMBO_RSVD = 2'h3
    } pesc_jumbo_t;
endpackage
`default_nettype wire

// ===== logic/pesc_sat_counter.sv
// Eight-bit saturating event counter that clears on read.
// Assumes event and read strobes are single-cycle pulses on ref_clk.
`timescale 1ns/1ns
`default_nettype none
`include "pesc_params.svh"
module pesc_sat_counter
    import pesc_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic event_pulse,
    input wire logic rd_clear,
    output logic [WIDTH-1:0] count
);
    // The counter width must match the eight-bit field.
    initial begin
        if (WIDTH != 8) begin
            $error("pesc_sat_counter supports only WIDTH 8.");
        end
    end

    // ==========================================
    // Counter state.
    logic [WIDTH-1:0] cnt_r; // Current count.
    logic [WIDTH-1:0] cnt_nxt; // Next count.

    // Next count: a read clears, an event in the same cycle leaves one.
    always_comb begin
        cnt_nxt = cnt_r;
        if (rd_clear) begin
            cnt_nxt = event_pulse ? `PESC_CNT_ONE : `PESC_CNT_ZERO;
        end else if (event_pulse && cnt_r != `PESC_CNT_MAX) begin
            cnt_nxt = cnt_r + `PESC_CNT_ONE;
        end
    end

    // Register the count.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_r <= `PESC_CNT_ZERO;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign count = cnt_r;
endmodule // pesc_sat_counter
`default_nettype wire

// ===== logic/pesc_regs.sv
// Per-port extended management registers, addresses 19 to 24.
// Assumes one-cycle management strobes with an address,
// and one-cycle datapath event pulses, all on ref_clk.
// Operation
// - Counters are 8-bit, saturate, clear on read.
// - Address 19 counts 100/1000 receive errors.
// - Address 20 counts 100/1000 false carriers.
// - Address 21 counts copper link disconnects.
// - Force bit bypasses link test, reports pass.
// - Sticky bit 14 disables jabber, resets 0.
// - Bits 13/12 disable echo/heartbeat, default 1.
// - Squelch field selects threshold, default normal.
// - Sticky-reset enable keeps sticky bits on software reset.
// - Super-sticky bits survive every software reset.
// - EOF error bit latches, clears on read.
// - 10BASE-T disconnect bit latches, clears on read.
// - Read-only bit 6 shows 10BASE-T link.
// - Broadcast bit applies writes to all ports.
// - Reads return only the addressed port.
// - Media mode field super-sticky, default copper.
// - Mode reads return the active mode.
// - Edge-rate field codes, default 001.
// - Jumbo field selects maximum packet length.
`timescale 1ns/1ns
`default_nettype none
`include "pesc_params.svh"
module pesc_regs
    import pesc_pkg::*;
#(
    parameter int CNT_WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic soft_reset,
    input wire logic [4:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic bcast_wr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic bcast_en,
    input wire logic rx_err_evt,
    input wire logic false_carrier_evt,
    input wire logic link_drop_evt,
    input wire logic eof_err_evt,
    input wire logic disc_10_evt,
    input wire logic link_10_ok,
    output logic link_10_pass,
    output logic jabber_dis,
    output logic echo_dis,
    output logic heartbeat_test_dis,
    output pesc_sq_t squelch_sel,
    output logic [2:0] media_mode,
    output logic far_end_loopback,
    output logic [2:0] edge_rate,
    output logic reduced_power,
    output pesc_jumbo_t jumbo_sel,
    output logic connector_loopback
);
    // Refuse widths the counter module cannot serve.
    initial begin
        if (CNT_WIDTH != 8) begin
            $error("pesc_regs supports only CNT_WIDTH 8.");
        end
    end

    // ==========================================
    // Address decode helper.

    // True when a strobe address names a register.
    function automatic logic hit(input logic [4:0] a, input logic [4:0] want);
        hit = (a == want);
    endfunction

    logic wr_any; // A write reaches this port, own or broadcast.
    logic rd_rx; // Clearing read of the receive error counter.
    logic rd_fc; // Clearing read of the false carrier counter.
    logic rd_ld; // Clearing read of the link drop counter.
    logic rd_ecs; // Read of the extended control/status register.

    // Broadcast writes from another port land here too; reads never do.
    assign wr_any = reg_wr | bcast_wr;
    assign rd_rx = reg_rd & hit(reg_addr, `PESC_ADDR_RXERR);
    assign rd_fc = reg_rd & hit(reg_addr, `PESC_ADDR_FCAR);
    assign rd_ld = reg_rd & hit(reg_addr, `PESC_ADDR_LDROP);
    assign rd_ecs = reg_rd & hit(reg_addr, `PESC_ADDR_ECS);

    // ==========================================
    // Error counters.
    logic [CNT_WIDTH-1:0] cnt_val [3]; // Counter values by index.
    logic [2:0] cnt_evt; // Event pulses by index.
    logic [2:0] cnt_rd; // Clearing reads by index.

    assign cnt_evt = {link_drop_evt, false_carrier_evt, rx_err_evt};
    assign cnt_rd = {rd_ld, rd_fc, rd_rx};

    // One saturating counter each for the receive error, false carrier and link drop events.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_cnt
            pesc_sat_counter #(
                .WIDTH(CNT_WIDTH)
            ) u_cnt (
                .ref_clk(ref_clk),
                .rst(rst),
                .event_pulse(cnt_evt[gi]),
                .rd_clear(cnt_rd[gi]),
                .count(cnt_val[gi])
            );
        end
    endgenerate

    // ==========================================
    // Control fields.
    logic force_r, force_nxt; // Link integrity bypass, sticky.
    logic jab_r, jab_nxt; // Jabber detect disable, sticky.
    logic echo_r, echo_nxt; // Echo disable, sticky.
    logic hbt_r, hbt_nxt; // Heartbeat test disable, sticky.
    logic [1:0] sq_r, sq_nxt; // Squelch select, sticky.
    logic stken_r, stken_nxt; // Sticky-reset enable, super-sticky.
    logic bcast_r, bcast_nxt; // Broadcast write enable, sticky.
    logic [2:0] mode_pend_r, mode_pend_nxt; // Written media mode, super-sticky.
    logic [2:0] mode_act_r, mode_act_nxt; // Media mode in effect.
    logic [4:0] rsvw_r, rsvw_nxt; // Writable reserved bits.
    logic felb_r, felb_nxt; // Far-end loopback.
    logic [2:0] edge_r, edge_nxt; // Edge rate, sticky.
    logic rpwr_r, rpwr_nxt; // Reduced power mode, sticky.
    logic [1:0] jumbo_r, jumbo_nxt; // Jumbo mode, sticky.
    logic clb_r, clb_nxt; // Connector loopback.
    logic eof_r, eof_nxt; // Latched end-of-frame error.
    logic disc_r, disc_nxt; // Latched 10BASE-T disconnect.
    logic wr_ecs, wr_e1, wr_e2; // Register write selects.
    logic keep_sticky; // Soft reset keeps sticky values.

    assign wr_ecs = wr_any & hit(reg_addr, `PESC_ADDR_ECS);
    assign wr_e1 = wr_any & hit(reg_addr, `PESC_ADDR_EPC1);
    assign wr_e2 = wr_any & hit(reg_addr, `PESC_ADDR_EPC2);
    assign keep_sticky = stken_r;

    // Next values: soft reset first, then writes.
    always_comb begin
        force_nxt = force_r;
        jab_nxt = jab_r;
        echo_nxt = echo_r;
        hbt_nxt = hbt_r;
        sq_nxt = sq_r;
        stken_nxt = stken_r;
        bcast_nxt = bcast_r;
        mode_pend_nxt = mode_pend_r;
        mode_act_nxt = mode_act_r;
        rsvw_nxt = rsvw_r;
        felb_nxt = felb_r;
        edge_nxt = edge_r;
        rpwr_nxt = rpwr_r;
        jumbo_nxt = jumbo_r;
        clb_nxt = clb_r;
        if (soft_reset) begin
            // Pending mode and sticky-reset enable are never touched here; the active mode loads the pending one.
            mode_act_nxt = mode_pend_r;
            felb_nxt = `PESC_RST_BIT;
            clb_nxt = `PESC_RST_BIT;
            rsvw_nxt = `PESC_RST_RSVW;
            if (!keep_sticky) begin
                // Sticky bits fall back to their defaults.
                force_nxt = `PESC_RST_FORCE;
                jab_nxt = `PESC_RST_JAB;
                echo_nxt = `PESC_RST_ECHO;
                hbt_nxt = `PESC_RST_HBT;
                sq_nxt = `PESC_RST_SQ;
                bcast_nxt = `PESC_RST_BCAST;
                edge_nxt = `PESC_RST_EDGE;
                rpwr_nxt = `PESC_RST_BIT;
                jumbo_nxt = `PESC_RST_JUMBO;
            end
        end else begin
            if (wr_ecs) begin
                // Bits 8:1 are read-only and drop the write.
                force_nxt = reg_wdata[`PESC_ECS_FORCE];
                jab_nxt = reg_wdata[`PESC_ECS_JAB];
                echo_nxt = reg_wdata[`PESC_ECS_ECHO];
                hbt_nxt = reg_wdata[`PESC_ECS_HBT];
                sq_nxt = reg_wdata[`PESC_ECS_SQ_HI:`PESC_ECS_SQ_LO];
                stken_nxt = reg_wdata[`PESC_ECS_STKEN];
                bcast_nxt = reg_wdata[`PESC_ECS_BCAST];
            end
            if (wr_e1) begin
                // The mode waits for the next soft reset.
                mode_pend_nxt = reg_wdata[`PESC_EPC1_MODE_HI:`PESC_EPC1_MODE_LO];
                rsvw_nxt = reg_wdata[`PESC_EPC1_RSVW_HI:`PESC_EPC1_RSVW_LO];
                felb_nxt = reg_wdata[`PESC_EPC1_FELB];
            end
            if (wr_e2) begin
                edge_nxt = reg_wdata[`PESC_EPC2_EDGE_HI:`PESC_EPC2_EDGE_LO];
                rpwr_nxt = reg_wdata[`PESC_EPC2_RPWR];
                jumbo_nxt = reg_wdata[`PESC_EPC2_JUMBO_HI:`PESC_EPC2_JUMBO_LO];
                clb_nxt = reg_wdata[`PESC_EPC2_CLB];
            end
        end
    end

    // Latched events: the set wins over a clearing read in the same cycle.
    always_comb begin
        eof_nxt = eof_r;
        disc_nxt = disc_r;
        if (rd_ecs) begin
            eof_nxt = `PESC_RST_BIT;
            disc_nxt = `PESC_RST_BIT;
        end
        if (eof_err_evt) begin
            eof_nxt = 1'h1;
        end
        if (disc_10_evt) begin
            disc_nxt = 1'h1;
        end
    end

    // Register all control and status state.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            force_r <= `PESC_RST_FORCE;
            jab_r <= `PESC_RST_JAB;
            echo_r <= `PESC_RST_ECHO;
            hbt_r <= `PESC_RST_HBT;
            sq_r <= `PESC_RST_SQ;
            stken_r <= `PESC_RST_STKEN;
            bcast_r <= `PESC_RST_BCAST;
            mode_pend_r <= `PESC_RST_MODE;
            mode_act_r <= `PESC_RST_MODE;
            rsvw_r <= `PESC_RST_RSVW;
            felb_r <= `PESC_RST_BIT;
            edge_r <= `PESC_RST_EDGE;
            rpwr_r <= `PESC_RST_BIT;
            jumbo_r <= `PESC_RST_JUMBO;
            clb_r <= `PESC_RST_BIT;
            eof_r <= `PESC_RST_BIT;
            disc_r <= `PESC_RST_BIT;
        end else begin
            force_r <= force_nxt;
            jab_r <= jab_nxt;
            echo_r <= echo_nxt;
            hbt_r <= hbt_nxt;
            sq_r <= sq_nxt;
            stken_r <= stken_nxt;
            bcast_r <= bcast_nxt;
            mode_pend_r <= mode_pend_nxt;
            mode_act_r <= mode_act_nxt;
            rsvw_r <= rsvw_nxt;
            felb_r <= felb_nxt;
            edge_r <= edge_nxt;
            rpwr_r <= rpwr_nxt;
            jumbo_r <= jumbo_nxt;
            clb_r <= clb_nxt;
            eof_r <= eof_nxt;
            disc_r <= disc_nxt;
        end
    end

    // ==========================================
    // Read data, registered; reserved bits stay zero except the writable ones.
    logic [15:0] rdata_r, rdata_nxt; // Read data holding register.

    // Builds the addressed word; only this port's state is visible.
    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd) begin
            rdata_nxt = 16'h0000;
            case (reg_addr)
                `PESC_ADDR_RXERR: rdata_nxt[CNT_WIDTH-1:0] = cnt_val[0];
                `PESC_ADDR_FCAR: rdata_nxt[CNT_WIDTH-1:0] = cnt_val[1];
                `PESC_ADDR_LDROP: rdata_nxt[CNT_WIDTH-1:0] = cnt_val[2];
                `PESC_ADDR_ECS: begin
                    rdata_nxt[`PESC_ECS_FORCE] = force_r;
                    rdata_nxt[`PESC_ECS_JAB] = jab_r;
                    rdata_nxt[`PESC_ECS_ECHO] = echo_r;
                    rdata_nxt[`PESC_ECS_HBT] = hbt_r;
                    rdata_nxt[`PESC_ECS_SQ_HI:`PESC_ECS_SQ_LO] = sq_r;
                    rdata_nxt[`PESC_ECS_STKEN] = stken_r;
                    rdata_nxt[`PESC_ECS_EOF] = eof_r;
                    rdata_nxt[`PESC_ECS_DISC] = disc_r;
                    rdata_nxt[`PESC_ECS_LINK] = link_10_pass;
                    rdata_nxt[`PESC_ECS_BCAST] = bcast_r;
                end
                `PESC_ADDR_EPC1: begin
                    rdata_nxt[`PESC_EPC1_RSVW_HI:`PESC_EPC1_RSVW_LO] = rsvw_r;
                    rdata_nxt[`PESC_EPC1_MODE_HI:`PESC_EPC1_MODE_LO] = mode_act_r;
                    rdata_nxt[`PESC_EPC1_FELB] = felb_r;
                end
                `PESC_ADDR_EPC2: begin
                    rdata_nxt[`PESC_EPC2_EDGE_HI:`PESC_EPC2_EDGE_LO] = edge_r;
                    rdata_nxt[`PESC_EPC2_RPWR] = rpwr_r;
                    rdata_nxt[`PESC_EPC2_JUMBO_HI:`PESC_EPC2_JUMBO_LO] = jumbo_r;
                    rdata_nxt[`PESC_EPC2_CLB] = clb_r;
                end
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    // Register the read data.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // ==========================================
    // Outputs to the PHY datapath.
    assign reg_rdata = rdata_r;
    assign bcast_en = bcast_r;
    assign link_10_pass = force_r | link_10_ok;
    assign jabber_dis = jab_r;
    assign echo_dis = echo_r;
    assign heartbeat_test_dis = hbt_r;
    assign squelch_sel = pesc_sq_t'(sq_r);
    assign media_mode = mode_act_r;
    assign far_end_loopback = felb_r;
    assign edge_rate = edge_r;
    assign reduced_power = rpwr_r;
    assign jumbo_sel = pesc_jumbo_t'(jumbo_r);
    assign connector_loopback = clb_r;
endmodule // pesc_regs
`default_nettype wire

// ===== test/pesc_regs_properties.sv
// Checker of the status register block, on its ports only.
// Assumes it is bound onto every instance of pesc_regs.
`timescale 1ns/1ns
`default_nettype none
module pesc_regs_properties
    import pesc_pkg::*;
#(
    parameter int CNT_WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic soft_reset,
    input wire logic [4:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic bcast_wr,
    input wire logic [15:0] reg_rdata,
    input wire logic bcast_en,
    input wire logic link_10_ok,
    input wire logic link_10_pass,
    input wire logic jabber_dis,
    input wire logic echo_dis,
    input wire logic heartbeat_test_dis,
    input wire pesc_sq_t squelch_sel,
    input wire logic [2:0] media_mode,
    input wire logic [2:0] edge_rate,
    input wire pesc_jumbo_t jumbo_sel
);
    // ==========================================
    // Helpers and defaults.
    // A read with no write or soft reset beside it sees settled fields.
    logic quiet;
    assign quiet = !reg_wr && !bcast_wr && !soft_reset;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // ==========================================
    // Assertions.
    AST_CNT_RSV: assert property (reg_rd && reg_addr inside {5'h13, 5'h14, 5'h15}
        |=> reg_rdata[15:CNT_WIDTH] == '0) else $error("counter upper bits not zero");
    AST_UNMAPPED_ZERO: assert property (reg_rd && !(reg_addr inside {[5'h13:5'h18]})
        |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
    AST_ECS_READ: assert property (reg_rd && reg_addr == 5'h16 && quiet
        |=> reg_rdata[11:10] == squelch_sel && reg_rdata[14] == jabber_dis
        && reg_rdata[5:1] == 5'h00) else $error("status read differs");
    AST_BCAST_READ: assert property (reg_rd && reg_addr == 5'h16 && quiet
        |=> reg_rdata[0] == bcast_en) else $error("broadcast bit read differs");
    AST_LINK_PASS: assert property (link_10_ok |-> link_10_pass)
        else $error("link pass missing");
    AST_MODE_READ: assert property (reg_rd && reg_addr == 5'h17 && quiet
        |=> reg_rdata[10:8] == media_mode) else $error("mode read not active mode");
    AST_MODE_HOLD: assert property (!soft_reset |=> $stable(media_mode))
        else $error("mode moved without soft reset");
    AST_EDGE_READ: assert property (reg_rd && reg_addr == 5'h18 && quiet
        |=> reg_rdata[15:13] == edge_rate && reg_rdata[5:4] == jumbo_sel)
        else $error("control read differs");
    AST_RST_DEFAULT: assert property (disable iff (1'b0) rst |=> echo_dis
        && heartbeat_test_dis && !jabber_dis && edge_rate == 3'h1)
        else $error("reset defaults wrong");
    AST_RDATA_STANDS: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");

    // Main scenarios reached.
    cover property (reg_rd && reg_addr == 5'h15 ##1 reg_rdata[7:0] == 8'hff);
    cover property (bcast_wr);
    cover property (soft_reset ##1 $changed(media_mode));
endmodule // pesc_regs_properties

bind pesc_regs pesc_regs_properties #(.CNT_WIDTH(CNT_WIDTH)) i_props (.*);
`default_nettype wire

// ===== test/pesc_mgmt_model.sv
// Management controller model that issues register cycles and soft resets.
// Assumes the block takes each strobe at the rising ref_clk edge.
`timescale 1ns/1ns
`default_nettype none
module pesc_mgmt_model (
    input wire logic ref_clk,
    output logic soft_reset,
    output logic [4:0] reg_addr,
    output logic reg_rd,
    output logic reg_wr,
    output logic bcast_wr,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata
);
    // ==========================================
    // Idle state at time zero.
    initial begin
        {soft_reset, reg_addr, reg_rd, reg_wr, bcast_wr, reg_wdata} = '0;
    end

    // One write; bc marks a write fanned in from another port.
    // Address and data are inverted on release.
    task automatic wr(input logic bc, input logic [4:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= !bc;
        bcast_wr <= bc;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        bcast_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    // One read; the data stands from the edge that takes the strobe.
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge ref_clk);
        d = reg_rdata;
    endtask

    // Soft reset pulse, which makes a pending mode change active.
    task automatic sreset();
        @(posedge ref_clk);
        soft_reset <= 1'b1;
        @(posedge ref_clk);
        soft_reset <= 1'b0;
    endtask
endmodule // pesc_mgmt_model
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench of the extended status register block.
// Assumes the model and the bound checker are compiled with it.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import pesc_pkg::*;
    // ==========================================
    // Signals, shadows and counters.
    logic ref_clk, rst, link_10_ok, soft_reset, reg_rd, reg_wr, bcast_wr;
    logic [4:0] evt; // Event pulses, in port order.
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, sh16, sh17, sh18, got;
    logic bcast_en, link_10_pass, jabber_dis, echo_dis, heartbeat_test_dis;
    logic far_end_loopback, reduced_power, connector_loopback;
    logic [2:0] media_mode, edge_rate, mode_act, mode_pend;
    pesc_sq_t squelch_sel;
    pesc_jumbo_t jumbo_sel;
    logic [7:0] cnt [3];
    logic [31:0] r;
    int fails, tests_run;

    pesc_regs i_dut (.ref_clk, .rst, .soft_reset, .reg_addr, .reg_rd, .reg_wr, .bcast_wr,
        .reg_wdata, .reg_rdata, .bcast_en, .rx_err_evt(evt[0]), .false_carrier_evt(evt[1]),
        .link_drop_evt(evt[2]), .eof_err_evt(evt[3]), .disc_10_evt(evt[4]), .link_10_ok,
        .link_10_pass, .jabber_dis, .echo_dis, .heartbeat_test_dis, .squelch_sel, .media_mode,
        .far_end_loopback, .edge_rate, .reduced_power, .jumbo_sel, .connector_loopback);
    pesc_mgmt_model i_mgmt (.ref_clk, .soft_reset, .reg_addr, .reg_rd, .reg_wr, .bcast_wr,
        .reg_wdata, .reg_rdata);

    // ==========================================
    // Expectation and comparison helpers.
    // Expected read word from the shadows; reserved places other than the writable ones are zero.
    function automatic logic [15:0] exp_rd(input logic [4:0] a);
        case (a)
            5'h13, 5'h14, 5'h15: exp_rd = {8'h00, cnt[a - 5'h13]};
            5'h16: exp_rd = sh16 | {9'h000, link_10_ok | sh16[15], 6'h00};
            5'h17: exp_rd = sh17 | {5'h00, mode_act, 8'h00};
            5'h18: exp_rd = sh18;
            default: exp_rd = 16'h0000;
        endcase
    endfunction
    task automatic chk_reg(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_pin(input logic [2:0] g, input logic [2:0] e);
        chk_reg({13'h0, g}, {13'h0, e});
    endtask
    // Read and compare; x adds latched bits; counters clear on read.
    task automatic rd_cmp(input logic [4:0] a, input logic [15:0] x);
        i_mgmt.rd(a, got);
        chk_reg(got, exp_rd(a) | x);
        if (a inside {5'h13, 5'h14, 5'h15}) cnt[a - 5'h13] = 8'h00;
    endtask
    // Write and keep the shadows in step; the mode only goes to pending.
    task automatic wr_sh(input logic bc, input logic [4:0] a, input logic [15:0] d);
        i_mgmt.wr(bc, a, d);
        if (a == 5'h16) sh16 = d & 16'hfe01;
        if (a == 5'h17) sh17 = d & 16'hf808;
        if (a == 5'h17) mode_pend = d[10:8];
        if (a == 5'h18) sh18 = d & 16'hf031;
    endtask
    // Soft reset: sticky fields fall to defaults only with the enable clear.
    task automatic sreset_sh();
        i_mgmt.sreset();
        mode_act = mode_pend;
        sh17 = 16'h0000;
        sh18 = sh16[9] ? (sh18 & 16'hf030) : 16'h2000;
        if (!sh16[9]) sh16 = 16'h3000;
    endtask
    // Event pulses; the three counters saturate in the shadow.
    task automatic pulse(input int k, input int n);
        repeat (n) begin
            @(posedge ref_clk) evt[k] <= 1'b1;
            @(posedge ref_clk) evt[k] <= 1'b0;
            if (k < 3 && cnt[k] != 8'hff) cnt[k]++;
        end
    endtask
    // Every control output against the shadows.
    task automatic chk_outs();
        #1;
        chk_pin(link_10_pass, sh16[15] | link_10_ok);
        chk_pin(jabber_dis, sh16[14]);
        chk_pin(echo_dis, sh16[13]);
        chk_pin(heartbeat_test_dis, sh16[12]);
        chk_pin(squelch_sel, sh16[11:10]);
        chk_pin(bcast_en, sh16[0]);
        chk_pin(media_mode, mode_act);
        chk_pin(far_end_loopback, sh17[3]);
        chk_pin(edge_rate, sh18[15:13]);
        chk_pin(reduced_power, sh18[12]);
        chk_pin(jumbo_sel, sh18[5:4]);
        chk_pin(connector_loopback, sh18[0]);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ==========================================
    // Clock and watchdog.
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        $display("MISMATCH %0t watchdog expired", $time);
        summarize();
    end

    // ==========================================
    // Main sequence.
    initial begin
        rst = 1'b1;
        link_10_ok = 1'b0;
        evt = 5'h00;
        fails = 0;
        tests_run = 0;
        {sh16, sh17, sh18, mode_act, mode_pend} = {16'h3200, 16'h0000, 16'h2000, 6'h00};
        cnt = '{8'h00, 8'h00, 8'h00};
        void'($urandom(32'h7f8b));
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        for (int a = 5'h13; a <= 5'h18; a++) rd_cmp(a[4:0], 16'h0000);
        rd_cmp(5'h05, 16'h0000);
        chk_outs();
        $display("test reset done");
        for (int k = 0; k < 3; k++) begin
            pulse(k, 1 + $urandom % 20);
            rd_cmp(5'h13 + k[4:0], 16'h0000);
            rd_cmp(5'h13 + k[4:0], 16'h0000);
        end
        pulse(2, 260);
        rd_cmp(5'h15, 16'h0000);
        pulse(1, 3);
        fork
            i_mgmt.rd(5'h14, got);
            pulse(1, 1);
        join
        chk_reg(got, 16'h0003);
        cnt[1] = 8'h01;
        rd_cmp(5'h14, 16'h0000);
        $display("test counters done");
        pulse(3, 1);
        rd_cmp(5'h16, 16'h0100);
        pulse(4, 1);
        rd_cmp(5'h16, 16'h0080);
        rd_cmp(5'h16, 16'h0000);
        @(posedge ref_clk) link_10_ok <= 1'b1;
        rd_cmp(5'h16, 16'h0000);
        chk_outs();
        $display("test status bits done");
        for (int i = 0; i < 8; i++) begin
            wr_sh(1'b0, 5'h18, 16'(i) << 13 | 16'(i % 4) << 4);
            wr_sh(1'b0, 5'h16, 16'h8200 | 16'(i % 4) << 10);
            chk_outs();
        end
        for (int i = 0; i < 12; i++) begin
            r = $urandom;
            @(posedge ref_clk) link_10_ok <= r[0];
            wr_sh(r[1], 5'h16 + 5'(r[3:2] % 3), r[31:16]);
            chk_outs();
            rd_cmp(5'h16 + 5'(r[3:2] % 3), 16'h0000);
        end
        wr_sh(1'b0, 5'h05, 16'hffff);
        rd_cmp(5'h05, 16'h0000);
        $display("test fields done");
        wr_sh(1'b0, 5'h17, 16'hfd08);
        rd_cmp(5'h17, 16'h0000);
        wr_sh(1'b0, 5'h16, 16'hc601);
        wr_sh(1'b1, 5'h18, 16'h7031);
        sreset_sh();
        chk_outs();
        rd_cmp(5'h17, 16'h0000);
        wr_sh(1'b0, 5'h16, 16'hc401);
        wr_sh(1'b0, 5'h17, 16'h0308);
        sreset_sh();
        chk_outs();
        sreset_sh();
        rd_cmp(5'h16, 16'h0000);
        rd_cmp(5'h17, 16'h0000);
        rd_cmp(5'h18, 16'h0000);
        $display("test soft reset done");
        summarize();
    end
endmodule // testbench
`default_nettype wire
